/* File: hw/flash_row_pkg.sv */
// Constants and carrier types for the program flash row writer.
// Assumes a single 200 MHz system clock and a synchronous high reset.
`default_nettype none
package flash_row_pkg;
   // Word and latch geometry
   localparam int WORD_W      = 14;
   localparam int LATCH_N     = 32;
   localparam int LATCH_IDX_W = 5;
   localparam int ROW_W       = 10;
   localparam int ADDR_W      = 15;
   // Address field positions inside the high:low pair
   localparam int ADDR_LATCH_LO = 0;
   localparam int ADDR_ROW_LO   = 5;
   // Blank value of an erased word and of an unloaded latch
   localparam logic [13:0] BLANK_WORD = 14'h3fff;
   // Reset values
   localparam logic [4:0]  IDX_RST  = 5'h00;
   localparam logic [9:0]  ROW_RST  = 10'h000;
   // Default cycle counts of one row program and one row erase operation
   localparam int PROG_NS     = 2000;
   localparam int CLK_NS      = 5;
   localparam int PROG_CYCLES = (PROG_NS + CLK_NS - 1) / CLK_NS;
   localparam int ERASE_NS     = 2000;
   localparam int ERASE_CYCLES = (ERASE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [11:0] CNT_RST = 12'h000;

   // Software-visible control bits of the memory control register
   typedef struct packed {
      logic write_allow;
      logic region_select;
      logic latch_only;
   } mem_control_one_s;

   // One word write toward the flash array
   typedef struct packed {
      logic              valid;
      logic [ROW_W-1:0]  row;
      logic [4:0]        col;
      logic [WORD_W-1:0] data;
   } array_write_s;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_PROGRAM = 2'b01,
      ST_ERASE   = 2'b10,
      ST_CLEAR   = 2'b11
   } seq_state_e;
endpackage
`default_nettype wire

/* File: hw/unlock_watch.sv */
// Watches the protected unlock sequence and pulses when it completes.
// Assumes the two key bytes arrive as same-clock write strobes.
`timescale 1ns/1ps
`default_nettype none
module unlock_watch (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   // Key writes and arming
   input  wire logic       key_wr_i,
   input  wire logic [7:0] key_data_i,
   input  wire logic       arm_i,
   // Completion pulse
   output logic            unlock_o
);
   localparam logic [7:0] KEY_ONE = 8'h55;
   localparam logic [7:0] KEY_TWO = 8'haa;

   logic got_one;         // First key seen on the previous write
   logic next_got_one;
   logic next_unlock;

   ////////////////////////////////////////////////////////////////////////
   // Any write other than the expected key aborts; a gap of idle cycles
   // is allowed, but any foreign write breaks the sequence.
   always_comb begin
      next_got_one = got_one;
      next_unlock  = 1'b0;
      if (key_wr_i) begin
         if (!got_one) begin
            next_got_one = (key_data_i == KEY_ONE);
         end else begin
            next_got_one = 1'b0;
            // Only a clean second key while armed raises the unlock pulse [R11]
            next_unlock  = (key_data_i == KEY_TWO) && arm_i;
         end
      end
   end

   // Registers only
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         got_one  <= 1'b0;
         unlock_o <= 1'b0;
      end else begin
         got_one  <= next_got_one;
         unlock_o <= next_unlock;
      end
   end

   // Interrupted sequence never pulses
   property p_unlock_needs_keys;
      @(posedge mclk_i) disable iff (sys_rst_i)
      unlock_o |-> $past(key_wr_i) && ($past(key_data_i) == KEY_TWO);
   endproperty
   a_unlock_needs_keys: assert property (p_unlock_needs_keys) // [R11]
      else $error("unlock pulse without second key");

   // Second key counts only straight after a first key
   property p_unlock_after_first;
      @(posedge mclk_i) disable iff (sys_rst_i)
      unlock_o |-> $past(got_one);
   endproperty
   a_unlock_after_first: assert property (p_unlock_after_first) // [R11]
      else $error("unlock pulse without first key");
endmodule
`default_nettype wire

/* File: hw/program_flash_row_writer.sv */
// Row writer for program flash: write latches, row commit and row erase.
// Assumes register writes come from same-clock core logic and that the
// flash array accepts one word write per cycle on the array port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R01) Software loads address, latches, then commits rows
// (R02) Programming never erases; erase is separate
// (R03) Erase clears exactly one whole row
// (R04) One commit writes up to thirty-two words
// (R05) Upper ten bits row, low five latch
// (R06) Commit stays inside the addressed row
// (R07) Latches return to blank after write
// (R08) Latches return to blank after erase
// (R09) Latch-only unlock loads one latch only
// (R10) Normal unlock loads last word, commits row
// (R11) Only an uninterrupted unlock starts anything; the code starts an erase on an armed erase request with no unlock
// (R12) Software sets write allow before loading
// (R13) Software clears region select before loading
// (R14) Software increments address after each load
// (R15) Completion flag set when program finishes
module program_flash_row_writer #(
   parameter int PROG_CYC  = flash_row_pkg::PROG_CYCLES,
   parameter int ERASE_CYC = flash_row_pkg::ERASE_CYCLES
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   // Register contents held by the core
   input  wire logic [6:0]  mem_addr_high_i,
   input  wire logic [7:0]  mem_addr_low_i,
   input  wire logic [5:0]  mem_data_high_i,
   input  wire logic [7:0]  mem_data_low_i,
   input  wire flash_row_pkg::mem_control_one_s mem_control_one_i,
   // Erase request and unlock key writes
   input  wire logic        erase_req_i,
   input  wire logic        key_wr_i,
   input  wire logic [7:0]  key_data_i,
   // Completion flag clear from software
   input  wire logic        done_clr_i,
   // Flash array write port
   output var flash_row_pkg::array_write_s array_wr_o,
   output logic             array_erase_o,
   // Status
   output logic             busy_o,
   output logic             mem_op_done_flag_o
);
   localparam logic [11:0] PROG_LAST  = 12'(PROG_CYC - 1);
   localparam logic [11:0] ERASE_LAST = 12'(ERASE_CYC - 1);
   localparam logic [11:0] LATCH_CNT  = 12'(flash_row_pkg::LATCH_N);

   // Latch bank, one word per column of the row
   logic [flash_row_pkg::WORD_W-1:0] latch [flash_row_pkg::LATCH_N];
   logic [flash_row_pkg::WORD_W-1:0] next_latch [flash_row_pkg::LATCH_N];

   flash_row_pkg::seq_state_e state;       // Sequencer state
   flash_row_pkg::seq_state_e next_state;
   logic [11:0]               cnt;         // Operation timer
   logic [11:0]               next_cnt;
   logic [4:0]                col;         // Commit column walker
   logic [4:0]                next_col;
   logic [9:0]                row;         // Row captured at start
   logic [9:0]                next_row;
   flash_row_pkg::array_write_s next_array_wr;
   logic                      next_erase;
   logic                      next_busy;
   logic                      next_done;
   logic                      unlock;      // Clean unlock pulse
   logic                      armed;       // Program space, writes allowed

   logic [9:0]  addr_row;                  // Row field of the address
   logic [4:0]  addr_col;                  // Latch field of the address
   logic [13:0] data_word;                 // Data pair as one word

   ////////////////////////////////////////////////////////////////////////
   // Address split: row from high[6:0]:low[7:5], latch from low[4:0]
   assign addr_row  = {mem_addr_high_i, mem_addr_low_i[7:5]};   // [R05]
   assign addr_col  = mem_addr_low_i[4:0];                      // [R05]
   assign data_word = {mem_data_high_i, mem_data_low_i};
   // Unlock only counts in program space with writes allowed; the
   // software ordering of these bits is the caller's job
   assign armed = mem_control_one_i.write_allow &&               // [R12]
                  !mem_control_one_i.region_select &&           // [R13]
                  (state == flash_row_pkg::ST_IDLE);

   // Unlock detector
   unlock_watch u_unlock (
      .mclk_i     (mclk_i),
      .sys_rst_i  (sys_rst_i),
      .key_wr_i   (key_wr_i),
      .key_data_i (key_data_i),
      .arm_i      (armed),
      .unlock_o   (unlock)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for sequencer, latches and outputs
   always_comb begin
      next_state    = state;
      next_cnt      = cnt;
      next_col      = col;
      next_row      = row;
      next_latch    = latch;
      next_array_wr = '0;
      next_erase    = 1'b0;
      next_done     = mem_op_done_flag_o;
      // Software clear loses to a same-cycle set below
      if (done_clr_i) begin
         next_done = 1'b0;
      end
      case (state)
         flash_row_pkg::ST_IDLE: begin
            if (unlock) begin
               // Store the addressed word in either mode [R09] [R10]
               next_latch[addr_col] = data_word;
               if (!mem_control_one_i.latch_only) begin
                  // Commit whole bank, no automatic erase first [R02] [R10]
                  next_row   = addr_row;
                  next_col   = flash_row_pkg::IDX_RST;
                  next_cnt   = flash_row_pkg::CNT_RST;
                  next_state = flash_row_pkg::ST_PROGRAM;
               end
            end else if (erase_req_i && armed && !key_wr_i) begin
               // Erase takes the one addressed row, nothing more [R03]
               next_row   = addr_row;
               next_cnt   = flash_row_pkg::CNT_RST;
               next_state = flash_row_pkg::ST_ERASE;
            end
         end
         flash_row_pkg::ST_PROGRAM: begin
            // One word per latch, then the port stays quiet for the rest
            // of the program time; a program time shorter than the latch
            // count would leave the upper columns unwritten
            if (cnt < LATCH_CNT) begin
               // Walk the 32 columns of the captured row only [R04] [R06]
               next_array_wr.valid = 1'b1;
               next_array_wr.row   = row;
               next_array_wr.col   = col;
               next_array_wr.data  = latch[col];
               next_col            = col + 5'h01;
            end
            next_cnt = cnt + 12'h001;
            if (cnt == PROG_LAST) begin
               next_state = flash_row_pkg::ST_CLEAR;
               next_done  = 1'b1;                               // [R15]
            end
         end
         flash_row_pkg::ST_ERASE: begin
            next_erase = 1'b1;
            next_cnt   = cnt + 12'h001;
            if (cnt == ERASE_LAST) begin
               next_state = flash_row_pkg::ST_CLEAR;
               next_done  = 1'b1;
            end
         end
         flash_row_pkg::ST_CLEAR: begin
            // Every latch back to blank after write or erase [R07] [R08]
            for (int i = 0; i < flash_row_pkg::LATCH_N; i++) begin
               next_latch[i] = flash_row_pkg::BLANK_WORD;
            end
            next_state = flash_row_pkg::ST_IDLE;
         end
         default: begin
            next_state = flash_row_pkg::ST_IDLE;
         end
      endcase
      next_busy = (next_state != flash_row_pkg::ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers; latches start blank so an unloaded one programs
   // the erased value
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state              <= flash_row_pkg::ST_IDLE;
         cnt                <= flash_row_pkg::CNT_RST;
         col                <= flash_row_pkg::IDX_RST;
         row                <= flash_row_pkg::ROW_RST;
         array_wr_o         <= '0;
         array_erase_o      <= 1'b0;
         busy_o             <= 1'b0;
         mem_op_done_flag_o <= 1'b0;
         for (int i = 0; i < flash_row_pkg::LATCH_N; i++) begin
            latch[i] <= flash_row_pkg::BLANK_WORD;              // [R08]
         end
      end else begin
         state              <= next_state;
         cnt                <= next_cnt;
         col                <= next_col;
         row                <= next_row;
         array_wr_o         <= next_array_wr;
         array_erase_o      <= next_erase;
         busy_o             <= next_busy;
         mem_op_done_flag_o <= next_done;
         latch              <= next_latch;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // Latch-only unlock never starts a program
   property p_latch_only_no_prog;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (unlock && mem_control_one_i.latch_only) |=>
         (state == flash_row_pkg::ST_IDLE);
   endproperty
   a_latch_only_no_prog: assert property (p_latch_only_no_prog) // [R09]
      else $error("latch-only unlock started an operation");

   // Latch-only unlock stores the data word at the addressed latch
   property p_latch_load;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (unlock && state == flash_row_pkg::ST_IDLE) |=>
         (latch[$past(addr_col)] == $past(data_word));
   endproperty
   a_latch_load: assert property (p_latch_load) // [R09]
      else $error("latch not loaded by unlock");

   // Normal unlock enters programming next cycle
   property p_commit_start;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (unlock && !mem_control_one_i.latch_only) |=>
         (state == flash_row_pkg::ST_PROGRAM) && (cnt == 12'h000);
   endproperty
   a_commit_start: assert property (p_commit_start) // [R10]
      else $error("commit did not start");

   // Array writes stay in the captured row
   property p_row_fixed;
      @(posedge mclk_i) disable iff (sys_rst_i)
      array_wr_o.valid |-> (array_wr_o.row == row);
   endproperty
   a_row_fixed: assert property (p_row_fixed) // [R06]
      else $error("array write left its row");

   // Column walk advances by one within 32 columns
   property p_col_walk;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (array_wr_o.valid && $past(array_wr_o.valid)) |->
         (array_wr_o.col == 5'($past(array_wr_o.col) + 5'h01));
   endproperty
   a_col_walk: assert property (p_col_walk) // [R04]
      else $error("column walk skipped");

   // No more words per commit than there are latches
   property p_word_limit;
      @(posedge mclk_i) disable iff (sys_rst_i)
      array_wr_o.valid |-> (cnt <= LATCH_CNT);
   endproperty
   a_word_limit: assert property (p_word_limit) // [R04]
      else $error("commit wrote more words than latches");

   // After clear, the first and last latches are blank
   property p_blank_after;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (state == flash_row_pkg::ST_CLEAR) |=>
         (latch[0] == flash_row_pkg::BLANK_WORD) &&
         (latch[31] == flash_row_pkg::BLANK_WORD);
   endproperty
   a_blank_after: assert property (p_blank_after) // [R07]
      else $error("latches not blank after operation");

   // Erase always ends in the clear state
   property p_erase_clears;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (state == flash_row_pkg::ST_ERASE && cnt == ERASE_LAST) |=>
         (state == flash_row_pkg::ST_CLEAR);
   endproperty
   a_erase_clears: assert property (p_erase_clears) // [R08]
      else $error("erase did not blank latches");

   // Programming never drives an erase
   property p_no_auto_erase;
      @(posedge mclk_i) disable iff (sys_rst_i)
      array_wr_o.valid |-> !array_erase_o;
   endproperty
   a_no_auto_erase: assert property (p_no_auto_erase) // [R02]
      else $error("erase during programming");

   // Erase only on a requested single row
   property p_erase_one_row;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (array_erase_o && $past(array_erase_o)) |-> $stable(row);
   endproperty
   a_erase_one_row: assert property (p_erase_one_row) // [R03]
      else $error("erase changed row");

   // Done flag rises at the end of programming
   property p_done_set;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (state == flash_row_pkg::ST_PROGRAM && cnt == PROG_LAST) |=>
         mem_op_done_flag_o;
   endproperty
   a_done_set: assert property (p_done_set) // [R15]
      else $error("done flag not set");

   // Nothing starts without a clean unlock or erase request
   property p_start_cause;
      @(posedge mclk_i) disable iff (sys_rst_i)
      ($past(state) == flash_row_pkg::ST_IDLE &&
       state == flash_row_pkg::ST_PROGRAM) |-> $past(unlock);
   endproperty
   a_start_cause: assert property (p_start_cause) // [R11]
      else $error("program started without unlock");
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the program flash row writer.
// Assumes the design alone is driven, inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int PROG  = 40;                  // Shortened program length
   localparam int ERASE = 40;                  // Shortened erase length
   logic                             mclk_i    = 1'b0;
   logic                             sys_rst_i = 1'b1;
   logic [6:0]                       addr_high = 7'h00;
   logic [7:0]                       addr_low  = 8'h00;
   logic [5:0]                       data_high = 6'h00;
   logic [7:0]                       data_low  = 8'h00;
   flash_row_pkg::mem_control_one_s  ctrl      = 3'h4; // Write allowed
   logic                             erase_req = 1'b0;
   logic                             key_wr    = 1'b0;
   logic [7:0]                       key_data  = 8'h00;
   logic                             done_clr  = 1'b0;
   flash_row_pkg::array_write_s      wr;
   logic                             erase_on;
   logic                             busy;
   logic                             done;
   flash_row_pkg::array_write_s      exp_q[$]; // Expected array writes
   logic [13:0]                      model[32]; // Latch contents
   int                               n_mismatch   = 0;
   int                               total_checks = 0;
   integer                           seed         = 32'hb2a7;

   program_flash_row_writer #(.PROG_CYC(PROG), .ERASE_CYC(ERASE)) i_dut (
      .mclk_i             (mclk_i),
      .sys_rst_i          (sys_rst_i),
      .mem_addr_high_i    (addr_high),
      .mem_addr_low_i     (addr_low),
      .mem_data_high_i    (data_high),
      .mem_data_low_i     (data_low),
      .mem_control_one_i  (ctrl),
      .erase_req_i        (erase_req),
      .key_wr_i           (key_wr),
      .key_data_i         (key_data),
      .done_clr_i         (done_clr),
      .array_wr_o         (wr),
      .array_erase_o      (erase_on),
      .busy_o             (busy),
      .mem_op_done_flag_o (done)
   );

   // 200 MHz clock
   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // Comparison and closing
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Each array write takes the oldest note; a write with none is stray
   always @(negedge mclk_i) begin
      if (wr.valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("stray_write", 32'h1, 32'h0);
         end else begin
            check("array_write", {2'h0, wr}, {2'h0, exp_q.pop_front()});
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Drivers
   task automatic set_word(input logic [9:0] row, input logic [4:0] col,
                           input logic [13:0] d);
      addr_high = row[9:3];
      addr_low  = {row[2:0], col};
      data_high = d[13:8];
      data_low  = d[7:0];
   endtask

   // Key bytes, one per cycle, strobe dropped after the last
   task automatic keys(input logic [23:0] seq, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge mclk_i);
         key_wr   = 1'b1;
         key_data = seq[8*i +: 8];
      end
      @(negedge mclk_i);
      key_wr = 1'b0;
   endtask

   task automatic load(input logic [9:0] row, input logic [4:0] col,
                       input logic [13:0] d);
      ctrl.latch_only = 1'b1;
      set_word(row, col, d);
      keys(24'h0055aa, 2);
      model[col] = d;
      repeat (3) @(negedge mclk_i);
   endtask

   // Waits out an operation; the flag must be up when busy drops
   task automatic wait_done(input logic [31:0] len, input string what);
      int i;
      int n;
      i = 0;
      n = 0;
      while (busy !== 1'b0 && i < 300) begin
         @(negedge mclk_i);
         n += (erase_on === 1'b1);
         i++;
      end
      check("busy_fall", {31'h0, busy}, 32'h0);
      if (what == "erase") check("erase_len", n, len);
      check("done_flag", {31'h0, done}, 32'h1);
      check("queue_left", exp_q.size(), 32'h0);
      foreach (model[c]) model[c] = flash_row_pkg::BLANK_WORD;
      // Clear the flag so the next operation must set it again
      @(negedge mclk_i);
      done_clr = 1'b1;
      @(negedge mclk_i);
      done_clr = 1'b0;
      check("done_clr", {31'h0, done}, 32'h0);
   endtask

   task automatic commit(input logic [9:0] row, input logic [4:0] col,
                         input logic [13:0] d);
      int i;
      ctrl.latch_only = 1'b0;
      set_word(row, col, d);
      model[col] = d;
      for (int k = 0; k < flash_row_pkg::LATCH_N; k++) begin
         exp_q.push_back({1'b1, row, k[4:0], model[k % 32]});
      end
      keys(24'h0055aa, 2);
      i = 0;
      while (busy !== 1'b1 && i < 10) begin
         @(negedge mclk_i);
         i++;
      end
      check("busy_rise", {31'h0, busy}, 32'h1);
      wait_done(PROG, "prog");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [9:0] row;
      foreach (model[c]) model[c] = flash_row_pkg::BLANK_WORD;
      repeat (2) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      check("busy_rst", {31'h0, busy}, 32'h0);
      check("done_rst", {31'h0, done}, 32'h0);
      // Random subset of latches, then commit on the last column
      row = $random(seed);
      for (int c = 0; c < 31; c++) begin
         if ($random(seed) & 1) load(row, c[4:0], $random(seed));
      end
      commit(row, 5'h1f, $random(seed));
      // Committed latches came back blank
      row = $random(seed);
      commit(row, $random(seed), $random(seed));
      // Erase blanks loaded latches and writes no word
      load(row, 5'h03, $random(seed));
      load(row, 5'h11, $random(seed));
      set_word(row, 5'h00, 14'h0000);
      @(negedge mclk_i);
      erase_req = 1'b1;
      @(negedge mclk_i);
      erase_req = 1'b0;
      wait_done(ERASE, "erase");
      commit(row, 5'h00, $random(seed));
      // Broken or unarmed unlocks start nothing
      ctrl = 3'h4;
      set_word(row, 5'h05, 14'h1234);
      keys(24'h5512aa, 3);
      repeat (8) @(negedge mclk_i);
      check("busy_abort", {31'h0, busy}, 32'h0);
      ctrl = 3'h0;
      keys(24'h0055aa, 2);
      repeat (8) @(negedge mclk_i);
      check("busy_unarmed", {31'h0, busy}, 32'h0);
      ctrl = 3'h6;
      keys(24'h0055aa, 2);
      repeat (8) @(negedge mclk_i);
      check("busy_region", {31'h0, busy}, 32'h0);
      conclude();
   end

   // Hang guard, well above the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge mclk_i);
      n_mismatch++;
      conclude();
   end
endmodule
`default_nettype wire
